// ===== bpcd_pkg.sv
// Package for the boot preset configuration decoder.
// Assumes a single 40 MHz clock and a 10-bit converter code spanning 0 to 1 V.
package bpcd_pkg;

  // ********************************************************************
  // Converter and decode thresholds
  // ********************************************************************
  localparam int ADC_W = 10;
  localparam int FULL_MV = 1000;
  // Lower bound in mV of presets 0..6, midpoints across gaps
  localparam int TH0_MV = 920;
  localparam int TH1_MV = 780;
  localparam int TH2_MV = 640;
  localparam int TH3_MV = 495;
  localparam int TH4_MV = 355;
  localparam int TH5_MV = 215;
  localparam int TH6_MV = 75;

  // ********************************************************************
  // Address, reset values and timing
  // ********************************************************************
  localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h61;
  localparam logic [2:0] PRESET_RST = 3'h0;
  localparam int CLK_MHZ = 40;
  localparam int WDOG_TIMEOUT_MS = 1000;
  localparam int WDOG_CYCLES = WDOG_TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int CLK_LOSS_US = 10;
  localparam int CLK_LOSS_CYCLES = CLK_LOSS_US * CLK_MHZ;
  localparam int WDOG_RST_PULSE = 16;

  // Clock frequency codes in kHz
  localparam logic [15:0] F_2048 = 16'h0800;
  localparam logic [15:0] F_2400 = 16'h0960;
  localparam logic [15:0] F_3072 = 16'h0C00;
  localparam logic [15:0] F_2800 = 16'h0AF0;
  localparam logic [15:0] F_19200 = 16'h4B00;
  localparam logic [15:0] F_26000 = 16'h6590;

  typedef enum logic [1:0] {
    BPCD_BOOT_IDLE = 2'b00,
    BPCD_BOOT_SAMPLE = 2'b01,
    BPCD_BOOT_DONE = 2'b10
  } bpcd_boot_t;

  typedef enum logic [1:0] {
    BPCD_OP_ACTIVE = 2'b00,
    BPCD_OP_BYPASS = 2'b01,
    BPCD_OP_STANDBY = 2'b10,
    BPCD_OP_SLEEP = 2'b11
  } bpcd_mode_t;

  typedef struct packed {
    logic [15:0] xclk_khz;
    logic dmic_stereo_ok;
    logic analog_mono_ok;
    logic close_talk_mode;
    logic [4:0] atten_db;
    logic use_pin_presets;
  } bpcd_cfg_t;

endpackage : bpcd_pkg

// ===== bpcd_top.sv
// Boot preset configuration decoder with watchdog and clock-loss monitor.
// Assumes converter codes arrive from a low-speed converter with a valid strobe.
`timescale 1ns/100ps
module bpcd_top
  import bpcd_pkg::*;
#(
  parameter int ADC_WIDTH = bpcd_pkg::ADC_W,
  parameter int WDOG_LIMIT = bpcd_pkg::WDOG_CYCLES,
  parameter int LOSS_LIMIT = bpcd_pkg::CLK_LOSS_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Boot control
  input wire logic boot_start,
  input wire logic boot_source_pin,
  input wire logic boot_mem_valid,
  // Low speed converter readings
  input wire logic [ADC_WIDTH-1:0] config_select_code,
  input wire logic [ADC_WIDTH-1:0] attenuation_select_code,
  input wire logic conv_valid,
  // Run-time monitoring
  input wire logic wdog_ack,
  input wire logic external_clock_input,
  input wire logic [1:0] mode_request,
  input wire logic mode_request_valid,
  // Results
  output bpcd_pkg::bpcd_cfg_t cfg,
  output logic [2:0] config_preset,
  output logic [2:0] attenuation_preset,
  output logic cfg_valid,
  output logic [6:0] i2c_target_addr,
  output logic sys_reset_req,
  output bpcd_pkg::bpcd_mode_t op_mode,
  output logic clock_lost
);
  import bpcd_pkg::*;

  // ********************************************************************
  // Voltage decoding
  // ********************************************************************
  function automatic logic [2:0] level_of(input logic [ADC_WIDTH-1:0] code);
    int mv;
    logic [2:0] idx;
    mv = (int'(code) * FULL_MV) / ((1 << ADC_WIDTH) - 1);
    if (mv >= TH0_MV) idx = 3'h0;
    else if (mv >= TH1_MV) idx = 3'h1;
    else if (mv >= TH2_MV) idx = 3'h2;
    else if (mv >= TH3_MV) idx = 3'h3;
    else if (mv >= TH4_MV) idx = 3'h4;
    else if (mv >= TH5_MV) idx = 3'h5;
    else if (mv >= TH6_MV) idx = 3'h6;
    else idx = 3'h7;
    return idx;
  endfunction : level_of

  wire [2:0] cfg_level = level_of(config_select_code);
  wire [2:0] att_level = level_of(attenuation_select_code);

  // ********************************************************************
  // Boot source pin synchroniser
  // ********************************************************************
  logic [2:0] bsrc_s_r;
  logic bsrc_lvl_r;
  // Level accepted once second and third stages agree
  wire bsrc_settled = bsrc_s_r[2] == bsrc_s_r[1];

  always_ff @(posedge clock) begin
    if (rst) begin
      bsrc_s_r <= 3'h7;
      bsrc_lvl_r <= 1'b1;
    end else begin
      bsrc_s_r <= {bsrc_s_r[1:0], boot_source_pin};
      if (bsrc_settled) bsrc_lvl_r <= bsrc_s_r[2];
    end
  end

  // Memory boot skipped on low pin, or fails on bad content
  wire pin_presets = !bsrc_lvl_r || !boot_mem_valid;

  // ********************************************************************
  // Boot sampling
  // ********************************************************************
  bpcd_boot_t boot_r, boot_nxt;
  logic [2:0] cfg_idx_r, att_idx_r;
  logic use_pins_r;
  wire take = (boot_r == BPCD_BOOT_SAMPLE) && conv_valid;

  always_comb begin
    boot_nxt = boot_r;
    unique case (boot_r)
      BPCD_BOOT_IDLE: if (boot_start) boot_nxt = BPCD_BOOT_SAMPLE;
      BPCD_BOOT_SAMPLE: if (conv_valid) boot_nxt = BPCD_BOOT_DONE;
      BPCD_BOOT_DONE: boot_nxt = BPCD_BOOT_DONE;
      default: boot_nxt = BPCD_BOOT_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      boot_r <= BPCD_BOOT_IDLE;
      cfg_idx_r <= PRESET_RST;
      att_idx_r <= PRESET_RST;
      use_pins_r <= 1'b0;
    end else begin
      boot_r <= boot_nxt;
      if (take) begin
        cfg_idx_r <= cfg_level;
        att_idx_r <= att_level;
        use_pins_r <= pin_presets;
      end
    end
  end

  // ********************************************************************
  // Preset tables
  // ********************************************************************
  logic [15:0] freq_sel;
  logic [4:0] att_db_sel;
  always_comb begin
    unique case (cfg_idx_r)
      3'h0, 3'h5: freq_sel = F_2048;
      3'h1: freq_sel = F_2400;
      3'h2: freq_sel = F_3072;
      3'h3: freq_sel = F_2800;
      3'h6: freq_sel = F_19200;
      3'h4, 3'h7: freq_sel = F_26000;
    endcase
    unique case (att_idx_r)
      3'h0: att_db_sel = 5'h00;
      3'h1: att_db_sel = 5'h0C;
      3'h2: att_db_sel = 5'h0F;
      3'h3: att_db_sel = 5'h12;
      3'h4: att_db_sel = 5'h15;
      3'h5: att_db_sel = 5'h18;
      3'h6: att_db_sel = 5'h1B;
      3'h7: att_db_sel = 5'h1E;
    endcase
  end
  wire stereo_ok = !(cfg_idx_r == 3'h4 || cfg_idx_r >= 3'h6);
  wire close_talk = cfg_idx_r >= 3'h5;

  bpcd_cfg_t cfg_nxt;
  assign cfg_nxt = '{xclk_khz: freq_sel, dmic_stereo_ok: stereo_ok,
                     analog_mono_ok: 1'b1, close_talk_mode: close_talk,
                     atten_db: att_db_sel, use_pin_presets: use_pins_r};

  // ********************************************************************
  // Watchdog
  // ********************************************************************
  localparam int WD_W = $clog2(WDOG_LIMIT + 1);
  localparam int RP_W = $clog2(WDOG_RST_PULSE + 1);
  logic [WD_W-1:0] wd_cnt_r;
  logic [RP_W-1:0] rp_cnt_r;
  wire wd_expire = (wd_cnt_r == WD_W'(WDOG_LIMIT - 1)) && !wdog_ack;

  always_ff @(posedge clock) begin
    if (rst) begin
      wd_cnt_r <= '0;
      rp_cnt_r <= '0;
    end else begin
      if (wdog_ack || wd_expire) wd_cnt_r <= '0;
      else wd_cnt_r <= wd_cnt_r + WD_W'(1);
      if (wd_expire) rp_cnt_r <= RP_W'(WDOG_RST_PULSE);
      else if (rp_cnt_r != '0) rp_cnt_r <= rp_cnt_r - RP_W'(1);
    end
  end

  // ********************************************************************
  // External clock monitor
  // ********************************************************************
  localparam int LS_W = $clog2(LOSS_LIMIT + 1);
  logic [2:0] xs_r;
  logic [LS_W-1:0] loss_cnt_r;
  logic lost_r;
  wire xedge = xs_r[2] != xs_r[1];
  wire lost_now = !xedge && (loss_cnt_r == LS_W'(LOSS_LIMIT - 1));

  always_ff @(posedge clock) begin
    if (rst) begin
      xs_r <= '0;
      loss_cnt_r <= '0;
      lost_r <= 1'b0;
    end else begin
      xs_r <= {xs_r[1:0], external_clock_input};
      if (xedge) loss_cnt_r <= '0;
      else if (!lost_now) loss_cnt_r <= loss_cnt_r + LS_W'(1);
      if (xedge) lost_r <= 1'b0;
      else if (lost_now) lost_r <= 1'b1;
    end
  end

  // ********************************************************************
  // Operating mode
  // ********************************************************************
  bpcd_mode_t mode_r, mode_nxt;
  logic loss_sleep_r;
  wire running = (mode_r == BPCD_OP_ACTIVE) || (mode_r == BPCD_OP_BYPASS);
  wire enter_loss = running && lost_now;
  wire wake = loss_sleep_r && xedge;

  always_comb begin
    mode_nxt = mode_r;
    if (enter_loss) mode_nxt = BPCD_OP_SLEEP;
    else if (wake) mode_nxt = BPCD_OP_ACTIVE;
    else if (mode_request_valid && !loss_sleep_r) mode_nxt = bpcd_mode_t'(mode_request);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_r <= BPCD_OP_ACTIVE;
      loss_sleep_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      if (enter_loss) loss_sleep_r <= 1'b1;
      else if (wake) loss_sleep_r <= 1'b0;
    end
  end

  // ********************************************************************
  // Registered outputs
  // ********************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg <= '0;
      config_preset <= PRESET_RST;
      attenuation_preset <= PRESET_RST;
      cfg_valid <= 1'b0;
      i2c_target_addr <= I2C_ADDR_DEFAULT;
      sys_reset_req <= 1'b0;
      op_mode <= BPCD_OP_ACTIVE;
      clock_lost <= 1'b0;
    end else begin
      cfg <= cfg_nxt;
      config_preset <= cfg_idx_r;
      attenuation_preset <= att_idx_r;
      cfg_valid <= boot_r == BPCD_BOOT_DONE;
      i2c_target_addr <= I2C_ADDR_DEFAULT;
      sys_reset_req <= wd_expire || (rp_cnt_r > RP_W'(1));
      op_mode <= mode_r;
      clock_lost <= lost_r;
    end
  end

endmodule : bpcd_top

// ===== bpcd_divider_model.sv
// Board resistive dividers on the two select pins.
// Assumes the converter spans 0 to 1 V over a 10-bit code.
`timescale 1ns/100ps
module bpcd_divider_model (
  // Pin voltages in mV
  input wire logic [9:0] cfg_mv,
  input wire logic [9:0] att_mv,
  // Converter codes
  output logic [9:0] cfg_code,
  output logic [9:0] att_code
);
  assign cfg_code = 10'((cfg_mv * 1023) / 1000);
  assign att_code = 10'((att_mv * 1023) / 1000);
endmodule : bpcd_divider_model

// ===== bpcd_top_assertions.sv
// Port checker for the boot preset decoder.
// Assumes it is bound to every bpcd_top instance.
`timescale 1ns/100ps
module bpcd_top_assertions
  import bpcd_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched signals
  input wire logic wdog_ack,
  input wire logic external_clock_input,
  input wire bpcd_pkg::bpcd_cfg_t cfg,
  input wire logic [2:0] config_preset,
  input wire logic [2:0] attenuation_preset,
  input wire logic cfg_valid,
  input wire logic [6:0] i2c_target_addr,
  input wire logic sys_reset_req,
  input wire bpcd_pkg::bpcd_mode_t op_mode,
  input wire logic clock_lost
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_addr_fixed: assert property (
    i2c_target_addr == 7'h61) else $error("target address wrong");
  a_stereo_map: assert property (
    cfg_valid |-> cfg.analog_mono_ok && cfg.dmic_stereo_ok ==
    (config_preset inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h5})) else $error("output stage wrong");
  a_mode_map: assert property (
    cfg_valid |-> cfg.close_talk_mode == (config_preset >= 3'h5)) else $error("mode wrong");
  a_atten_map: assert property (
    cfg_valid |-> cfg.atten_db == ((attenuation_preset == 3'h0) ? 5'h00 :
    5'(9 + 3 * attenuation_preset))) else $error("attenuation wrong");
  a_preset_held: assert property (
    cfg_valid |=> $stable(config_preset) && $stable(attenuation_preset))
    else $error("preset changed");
  a_wdog_pulse: assert property (
    $rose(sys_reset_req) |-> sys_reset_req [*8]) else $error("reset pulse short");
  a_ack_defers: assert property (
    wdog_ack |-> ##2 (!$rose(sys_reset_req)) [*8]) else $error("reset despite ack");
  a_loss_sleep: assert property (
    $rose(clock_lost) && $past(op_mode) inside {BPCD_OP_ACTIVE, BPCD_OP_BYPASS}
    |-> op_mode == BPCD_OP_SLEEP) else $error("no sleep on loss");
  a_sleep_holds: assert property (
    $stable(external_clock_input) [*6] ##0 (clock_lost && op_mode == BPCD_OP_SLEEP)
    |=> op_mode == BPCD_OP_SLEEP) else $error("left sleep early");
endmodule : bpcd_top_assertions
bind bpcd_top bpcd_top_assertions u_chk (.clock(clock), .rst(rst), .wdog_ack(wdog_ack),
  .external_clock_input(external_clock_input), .cfg(cfg), .config_preset(config_preset),
  .attenuation_preset(attenuation_preset), .cfg_valid(cfg_valid),
  .i2c_target_addr(i2c_target_addr), .sys_reset_req(sys_reset_req), .op_mode(op_mode),
  .clock_lost(clock_lost));

// ===== tb.sv
// Self-checking bench for the boot preset decoder.
// Assumes shortened watchdog and clock-loss limits.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
  import bpcd_pkg::*;
  logic clock = 0, rst = 1, boot_start = 0, boot_source_pin = 0, boot_mem_valid = 0;
  logic conv_valid = 0, wdog_ack = 0, xclk = 0, ext_run = 1, ack_on = 1, req_v = 0;
  logic [1:0] mode_request = 2'h0;
  logic [9:0] cfg_mv = 10'h000, att_mv = 10'h000, cfg_code, att_code;
  bpcd_cfg_t cfg;
  bpcd_mode_t op_mode;
  logic [2:0] config_preset, attenuation_preset;
  logic [6:0] i2c_target_addr;
  logic cfg_valid, sys_reset_req, clock_lost;
  logic [7:0] n;
  int failures = 0, n_tests = 0;
  logic [9:0] mid [8] = '{10'h3C5, 10'h352, 10'h2C6, 10'h235, 10'h1A9, 10'h11D, 10'h091, 10'h023};
  logic [15:0] ft [8] = '{16'h0800, 16'h0960, 16'h0C00, 16'h0AF0, 16'h6590, 16'h0800, 16'h4B00,
    16'h6590};
  logic [4:0] att_tab [8] = '{5'h00, 5'h0C, 5'h0F, 5'h12, 5'h15, 5'h18, 5'h1B, 5'h1E};
  logic [7:0] stereo_set = 8'h2F;
  bpcd_divider_model u_div (.cfg_mv(cfg_mv), .att_mv(att_mv), .cfg_code(cfg_code),
    .att_code(att_code));
  bpcd_top #(.ADC_WIDTH(10), .WDOG_LIMIT(50), .LOSS_LIMIT(20)) dut (.clock(clock), .rst(rst),
    .boot_start(boot_start), .boot_source_pin(boot_source_pin), .boot_mem_valid(boot_mem_valid),
    .config_select_code(cfg_code), .attenuation_select_code(att_code), .conv_valid(conv_valid),
    .wdog_ack(wdog_ack), .external_clock_input(xclk), .mode_request(mode_request),
    .mode_request_valid(req_v), .cfg(cfg), .config_preset(config_preset),
    .attenuation_preset(attenuation_preset), .cfg_valid(cfg_valid),
    .i2c_target_addr(i2c_target_addr), .sys_reset_req(sys_reset_req), .op_mode(op_mode),
    .clock_lost(clock_lost));
  initial forever #12.5 clock = ~clock;
  always @(negedge clock) wdog_ack <= ack_on && ($urandom_range(0, 3) == 0);
  always @(negedge clock) if (ext_run) xclk <= ~xclk;
  task automatic tick(input int k);
    repeat (k) @(negedge clock);
  endtask : tick
  function automatic logic [2:0] exp_idx(input logic [9:0] c);
    int mv;
    mv = c * 1000 / 1023;
    return mv >= TH0_MV ? 3'h0 : mv >= TH1_MV ? 3'h1 : mv >= TH2_MV ? 3'h2 : mv >= TH3_MV ? 3'h3 :
      mv >= TH4_MV ? 3'h4 : mv >= TH5_MV ? 3'h5 : mv >= TH6_MV ? 3'h6 : 3'h7;
  endfunction : exp_idx
  task automatic req_mode(input bpcd_mode_t m);
    mode_request = m;
    req_v = 1;
    tick(1);
    req_v = 0;
    tick(3);
  endtask : req_mode
  task automatic boot(input logic [9:0] cm, input logic [9:0] am);
    logic [2:0] ci, ai;
    rst = 1;
    tick(2);
    rst = 0;
    {boot_source_pin, boot_mem_valid} = 2'($urandom);
    cfg_mv = cm;
    att_mv = am;
    tick(4);
    boot_start = 1;
    tick(1);
    boot_start = 0;
    conv_valid = 1;
    tick(1);
    conv_valid = 0;
    tick(3);
    ci = exp_idx(cfg_code);
    ai = exp_idx(att_code);
    `CHK(config_preset, ci)
    `CHK(attenuation_preset, ai)
    `CHK(cfg.xclk_khz, ft[ci])
    `CHK(cfg.close_talk_mode, ci >= 3'h5)
    `CHK(cfg.atten_db, att_tab[ai])
    `CHK(cfg.dmic_stereo_ok, stereo_set[ci])
    `CHK(cfg.analog_mono_ok, 1'b1)
    `CHK(cfg.use_pin_presets, ~(boot_source_pin & boot_mem_valid))
    `CHK(cfg_valid, 1'b1)
    `CHK(i2c_target_addr, 7'h61)
    cfg_mv = 10'h3E8 - cm;
    att_mv = 10'h3E8 - am;
    boot_start = 1;
    conv_valid = 1;
    tick(2);
    boot_start = 0;
    conv_valid = 0;
    tick(3);
    `CHK(config_preset, ci)
    `CHK(attenuation_preset, ai)
    `CHK(sys_reset_req, 1'b0)
    $display("boot test cfg %0d att %0d done", ci, ai);
  endtask : boot
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h3AB6A996));
    for (int k = 0; k < 24; k++) begin
      if (k < 8) boot(mid[k], mid[7 - k]);
      else boot(10'($urandom_range(0, 1000)), 10'($urandom_range(0, 1000)));
    end
    req_mode(BPCD_OP_BYPASS);
    `CHK(op_mode, BPCD_OP_BYPASS)
    ext_run = 0;
    tick(30);
    `CHK(op_mode, BPCD_OP_SLEEP)
    `CHK(clock_lost, 1'b1)
    req_mode(BPCD_OP_ACTIVE);
    `CHK(op_mode, BPCD_OP_SLEEP)
    ext_run = 1;
    tick(8);
    `CHK(op_mode, BPCD_OP_ACTIVE)
    `CHK(clock_lost, 1'b0)
    $display("clock loss test done");
    req_mode(BPCD_OP_STANDBY);
    `CHK(op_mode, BPCD_OP_STANDBY)
    ext_run = 0;
    tick(30);
    `CHK(op_mode, BPCD_OP_STANDBY)
    `CHK(clock_lost, 1'b1)
    ext_run = 1;
    tick(8);
    `CHK(clock_lost, 1'b0)
    req_mode(BPCD_OP_SLEEP);
    `CHK(op_mode, BPCD_OP_SLEEP)
    $display("standby loss test done");
    ack_on = 0;
    n = 8'h00;
    repeat (80) if (sys_reset_req !== 1'b1) tick(1);
    while (sys_reset_req === 1'b1 && n < 8'h28) begin
      n++;
      tick(1);
    end
    `CHK(n, 8'h10)
    $display("watchdog test done");
    report_and_stop;
  end
endmodule : tb
